// ==== inc/swl_pkg.sv ====
// constants, types and carriers shared by the serial wiper latch loader
// Operation
// R1: chip select is active low and stays low for the whole time a word is shifted in.
// R2: on the chip select rising edge the multi-channel device decodes the address and loads only that latch.
// R3: the single-channel variant loads its one latch from the serial word when chip select returns high.
// R4: serial data is sampled on the rising serial clock edge and the host keeps it stable there.
// R5: while the midscale reset input is low every wiper latch is forced to 80 hex.
// R6: address 00 selects channel 1, 01 channel 2, 10 channel 3 and 11 channel 4.
// R7: one active-low power-down input shuts down all four channels of the quad variant, opening terminal A.
// R8: on the dual variant the one power-down input acts on both channels at once.
// R9: the serial output only pulls low or releases, and a system pull-up makes a released output read high.
// R10: a word is ten bits, two address bits then eight data bits, each group most significant bit first.
// R11: in power-down latches keep their codes, writes are still taken, the serial output is off, and wipers return to the latched codes afterwards.
// R12: the host sends address 00 to the single-channel variant and keeps the upper address bit 0 on the dual.
// R13: the serial output shows the bit leaving the far end of the serial input register for daisy chaining.
package swl_pkg;

   // ***************************************************************
   // word format and channel counts
   // ***************************************************************
   localparam int WORD_BITS = 10;
   localparam int ADDR_BITS = 2;
   localparam int CODE_BITS = 8;
   localparam int NUM_CH = 4;
   localparam int CH_SINGLE = 1;
   localparam int CH_DUAL = 2;
   localparam int CH_QUAD = 4;

   // ***************************************************************
   // codes, addresses and reset values
   // ***************************************************************
   localparam logic [CODE_BITS-1:0] MIDSCALE_CODE = 8'h80;
   localparam logic [CODE_BITS-1:0] WIPER_AT_B = 8'h00;
   localparam logic [ADDR_BITS-1:0] ADDR_CH1 = 2'h0;
   localparam logic [ADDR_BITS-1:0] ADDR_CH2 = 2'h1;
   localparam logic [ADDR_BITS-1:0] ADDR_CH3 = 2'h2;
   localparam logic [ADDR_BITS-1:0] ADDR_CH4 = 2'h3;
   localparam logic [NUM_CH-1:0] SEL_NONE = 4'h0;
   localparam logic [NUM_CH-1:0] SEL_CH1 = 4'h1;
   localparam logic [NUM_CH-1:0] SEL_CH2 = 4'h2;
   localparam logic [NUM_CH-1:0] SEL_CH3 = 4'h4;
   localparam logic [NUM_CH-1:0] SEL_CH4 = 4'h8;
   localparam logic [WORD_BITS-1:0] WORD_CLEAR = 10'h000;
   localparam logic [1:0] SYNC_HELD = 2'h3;
   localparam logic SYNC_RELEASE = 1'b0;
   localparam logic PIN_IDLE = 1'b1;
   localparam logic OD_LOW = 1'b0;

   // ***************************************************************
   // types and carriers
   // ***************************************************************
   typedef logic [CODE_BITS-1:0] swl_code_t;
   typedef logic [ADDR_BITS-1:0] swl_addr_t;

   // serial word as it sits in the input register, first bit on top
   typedef struct packed {
      swl_addr_t addr;
      swl_code_t code;
   } swl_word_s;

   // asynchronous pins entering the core clock domain
   typedef struct packed {
      logic cs_n;
      logic mrst_n;
      logic pd_n;
   } swl_pins_s;

   // glitch-free asynchronous controls from core to link side
   typedef struct packed {
      logic hold;
      logic off;
   } swl_link_ctl_s;

   typedef enum logic [1:0] {
      SWL_ST_ACTIVE = 2'h1,
      SWL_ST_SHUTDOWN = 2'h2
   } swl_mode_e;

endpackage : swl_pkg

// ==== core/swl_link_shift.sv ====
// serial input register and open-drain output on the serial clock
`timescale 1ns/1ps
`default_nettype none
module swl_link_shift (
   input wire logic link_clk,
   input wire swl_pkg::swl_link_ctl_s link_ctl,
   input wire logic chip_sel_n,
   input wire logic serial_in,
   output var swl_pkg::swl_word_s word,
   output var logic sdo_oe_n
);

   // ***************************************************************
   // state, split by asynchronous control
   // ***************************************************************
   typedef struct packed {
      logic [1:0] hsync;
      logic [swl_pkg::WORD_BITS-1:0] shift;
   } swl_shift_state_s;

   typedef struct packed {
      logic [1:0] osync;
      logic oe_n;
   } swl_sdo_state_s;

   localparam swl_shift_state_s SHIFT_RST = '{hsync: swl_pkg::SYNC_HELD, shift: swl_pkg::WORD_CLEAR};
   localparam swl_sdo_state_s SDO_RST = '{osync: swl_pkg::SYNC_HELD, oe_n: 1'b1};

   swl_shift_state_s sh_q;
   swl_shift_state_s sh_d;
   swl_sdo_state_s so_q;
   swl_sdo_state_s so_d;

   // ***************************************************************
   // next state
   // ***************************************************************
   // the serial clock only runs in frames, so the async controls are
   // released through a two-stage synchroniser on this clock
   always_comb begin
      sh_d = sh_q;
      so_d = so_q;
      sh_d.hsync = {sh_q.hsync[0], swl_pkg::SYNC_RELEASE};
      so_d.osync = {so_q.osync[0], swl_pkg::SYNC_RELEASE};
      if (sh_q.hsync[1]) begin
         sh_d.shift = swl_pkg::WORD_CLEAR;
      end else if (!chip_sel_n) begin // [R1] [R4] [R10]
         sh_d.shift = {sh_q.shift[swl_pkg::WORD_BITS-2:0], serial_in};
      end
      // pull low for a 0, release for a 1 or while powered down
      so_d.oe_n = so_q.osync[1] | sh_d.shift[swl_pkg::WORD_BITS-1]; // [R9] [R13] [R11]
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   // input register cleared only by the core reset
   always_ff @(posedge link_clk or posedge link_ctl.hold) begin
      if (link_ctl.hold) begin
         sh_q <= SHIFT_RST;
      end else begin
         sh_q <= sh_d;
      end
   end

   // output released at once on power-down, not at the next clock
   always_ff @(posedge link_clk or posedge link_ctl.off) begin
      if (link_ctl.off) begin
         so_q <= SDO_RST; // [R11]
      end else begin
         so_q <= so_d;
      end
   end

   assign word = swl_pkg::swl_word_s'(sh_q.shift);
   assign sdo_oe_n = so_q.oe_n;

endmodule : swl_link_shift
`default_nettype wire

// ==== core/swl_loader.sv ====
// wiper latch loader: pin synchronisers, address decode, latches, power-down
`timescale 1ns/1ps
`default_nettype none
module swl_loader #(
   parameter int CHANNELS = swl_pkg::CH_QUAD
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic link_clk,
   input wire logic chip_sel_n,
   input wire logic serial_in,
   input wire logic midscale_reset_n,
   input wire logic power_down_n,
   input wire logic serial_out_od_i,
   output var logic serial_out_od_o,
   output var logic serial_out_od_oe_n,
   output var swl_pkg::swl_code_t wiper_ch1,
   output var swl_pkg::swl_code_t wiper_ch2,
   output var swl_pkg::swl_code_t wiper_ch3,
   output var swl_pkg::swl_code_t wiper_ch4,
   output var logic [swl_pkg::NUM_CH-1:0] term_a_open,
   output var logic wiper_load
);

   // ***************************************************************
   // core state
   // ***************************************************************
   typedef struct packed {
      swl_pkg::swl_pins_s pin_s1;
      swl_pkg::swl_pins_s pin_s2;
      logic cs_prev;
      swl_pkg::swl_mode_e mode;
      logic [swl_pkg::NUM_CH-1:0][swl_pkg::CODE_BITS-1:0] latch;
      logic [swl_pkg::NUM_CH-1:0][swl_pkg::CODE_BITS-1:0] wiper;
      logic [swl_pkg::NUM_CH-1:0] a_open;
      logic load;
      logic sdo_lvl;
      swl_pkg::swl_link_ctl_s link;
   } swl_core_state_s;

   localparam swl_pkg::swl_pins_s PINS_IDLE = '{
      cs_n: swl_pkg::PIN_IDLE,
      mrst_n: swl_pkg::PIN_IDLE,
      pd_n: swl_pkg::PIN_IDLE
   };

   // reset holds the link side cleared and its output released
   localparam swl_core_state_s CORE_RST = '{
      pin_s1: PINS_IDLE,
      pin_s2: PINS_IDLE,
      cs_prev: swl_pkg::PIN_IDLE,
      mode: swl_pkg::SWL_ST_ACTIVE,
      latch: {swl_pkg::NUM_CH{swl_pkg::MIDSCALE_CODE}},
      wiper: {swl_pkg::NUM_CH{swl_pkg::MIDSCALE_CODE}},
      a_open: swl_pkg::SEL_NONE,
      load: 1'b0,
      sdo_lvl: swl_pkg::OD_LOW,
      link: '{hold: 1'b1, off: 1'b1}
   };

   swl_core_state_s q;
   swl_core_state_s d;

   // ***************************************************************
   // link side
   // ***************************************************************
   swl_pkg::swl_word_s link_word;
   logic link_oe_n;

   // input register and serial output live on the host's clock
   swl_link_shift u_link (
      .link_clk(link_clk),
      .link_ctl(q.link),
      .chip_sel_n(chip_sel_n),
      .serial_in(serial_in),
      .word(link_word),
      .sdo_oe_n(link_oe_n)
   );

   // ***************************************************************
   // address decode
   // ***************************************************************
   // one-hot latch select; channels the variant lacks are never hit
   function automatic logic [swl_pkg::NUM_CH-1:0] sel_decode(
      input swl_pkg::swl_addr_t addr,
      input int chans
   );
      logic [swl_pkg::NUM_CH-1:0] sel;
      sel = swl_pkg::SEL_NONE;
      if (chans == swl_pkg::CH_SINGLE) begin
         sel = swl_pkg::SEL_CH1; // [R3]
      end else begin
         unique case (addr) // [R6]
            swl_pkg::ADDR_CH1: sel = swl_pkg::SEL_CH1;
            swl_pkg::ADDR_CH2: sel = swl_pkg::SEL_CH2;
            swl_pkg::ADDR_CH3: sel = swl_pkg::SEL_CH3;
            swl_pkg::ADDR_CH4: sel = swl_pkg::SEL_CH4;
         endcase
         // a dual ignores writes aimed at the absent upper pair
         if (chans == swl_pkg::CH_DUAL) begin
            sel = sel & (swl_pkg::SEL_CH1 | swl_pkg::SEL_CH2); // [R12]
         end
      end
      return sel;
   endfunction : sel_decode

   // ***************************************************************
   // channel presence
   // ***************************************************************
   logic [swl_pkg::NUM_CH-1:0] present;

   // a channel exists when its index is below the variant's count
   generate
      for (genvar g = 0; g < swl_pkg::NUM_CH; g++) begin : g_present
         assign present[g] = (g < CHANNELS);
      end
   endgenerate

   // ***************************************************************
   // derived conditions
   // ***************************************************************
   logic cs_rise;
   logic mrst_act;
   logic pd_act;
   logic [swl_pkg::NUM_CH-1:0] sel;

   // only the second synchroniser stage and later are looked at
   assign cs_rise = q.pin_s2.cs_n & ~q.cs_prev; // [R1]
   assign mrst_act = ~q.pin_s2.mrst_n;
   assign pd_act = ~q.pin_s2.pd_n;

   // the link word is still here: the serial clock stands still
   // while chip select is high, so the register cannot move
   assign sel = cs_rise ? sel_decode(link_word.addr, CHANNELS) : swl_pkg::SEL_NONE; // [R2] [R3]

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      d = q;

      // two-flop synchronisers for the asynchronous pins
      d.pin_s1 = '{cs_n: chip_sel_n, mrst_n: midscale_reset_n, pd_n: power_down_n};
      d.pin_s2 = q.pin_s1;
      d.cs_prev = q.pin_s2.cs_n;

      // power-down mode, one input for every channel
      unique case (q.mode)
         swl_pkg::SWL_ST_ACTIVE: begin
            if (pd_act) begin
               d.mode = swl_pkg::SWL_ST_SHUTDOWN; // [R7] [R8]
            end
         end
         swl_pkg::SWL_ST_SHUTDOWN: begin
            if (!pd_act) begin
               d.mode = swl_pkg::SWL_ST_ACTIVE; // [R11]
            end
         end
         default: begin
            d.mode = swl_pkg::SWL_ST_ACTIVE;
         end
      endcase

      // latches: the midscale reset level beats a load in the same cycle
      for (int i = 0; i < swl_pkg::NUM_CH; i++) begin
         if (mrst_act) begin
            d.latch[i] = swl_pkg::MIDSCALE_CODE; // [R5]
         end else if (sel[i]) begin
            d.latch[i] = link_word.code; // [R2] [R10]
         end
      end

      // loads still land in power-down; the wiper sits at B meanwhile
      // and picks up the latched code as soon as the mode returns
      for (int i = 0; i < swl_pkg::NUM_CH; i++) begin
         if (d.mode == swl_pkg::SWL_ST_SHUTDOWN && present[i]) begin
            d.wiper[i] = swl_pkg::WIPER_AT_B; // [R11]
            d.a_open[i] = 1'b1; // [R7] [R8]
         end else begin
            d.wiper[i] = d.latch[i];
            d.a_open[i] = 1'b0;
         end
      end

      // one-cycle pulse for any latch load, even one masked by reset
      d.load = |sel;

      // the open-drain pin never drives high
      d.sdo_lvl = swl_pkg::OD_LOW; // [R9]

      // link controls come from flops so they never glitch
      d.link.hold = 1'b0;
      d.link.off = pd_act; // [R11]
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge core_clk) begin
      if (srst) begin
         q <= CORE_RST;
      end else begin
         q <= d;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   // pin level input is unused: the device never reads its own output
   logic sdo_unused;
   assign sdo_unused = serial_out_od_i;

   assign serial_out_od_o = q.sdo_lvl;
   // enable comes from the link-side flop, fast enough for chaining
   assign serial_out_od_oe_n = link_oe_n; // [R9] [R13]
   assign wiper_ch1 = q.wiper[0];
   assign wiper_ch2 = q.wiper[1];
   assign wiper_ch3 = q.wiper[2];
   assign wiper_ch4 = q.wiper[3];
   assign term_a_open = q.a_open;
   assign wiper_load = q.load;

endmodule : swl_loader
`default_nettype wire

// ==== verification/swl_host_model.sv ====
// host serial master model for the wiper loader link
`timescale 1ns/1ps
`default_nettype none
module swl_host_model (
   output var logic link_clk,
   output var logic chip_sel_n,
   output var logic serial_in
);
   // ****
   // frame generator
   // ****
   // clock stands still between frames, as a real host leaves it
   initial begin
      link_clk = 1'b0;
      chip_sel_n = 1'b1;
      serial_in = 1'b0;
   end

   // two filler bits lead each word since a reset eats two edges
   task automatic send(input logic [11:0] w);
      chip_sel_n = 1'b0;
      for (int i = 11; i >= 0; i--) begin
         serial_in = w[i];
         #24 link_clk = 1'b1;
         #24 link_clk = 1'b0;
      end
      #24 chip_sel_n = 1'b1;
      serial_in = ~w[0]; // no stale bit once deselected
   endtask : send
endmodule : swl_host_model
`default_nettype wire

// ==== verification/swl_loader_chk.sv ====
// assertion checker for the wiper loader top ports
`timescale 1ns/1ps
`default_nettype none
module swl_loader_chk #(
   parameter int CHANNELS = swl_pkg::CH_QUAD
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic link_clk,
   input wire logic chip_sel_n,
   input wire logic serial_in,
   input wire logic midscale_reset_n,
   input wire logic power_down_n,
   input wire logic serial_out_od_i,
   input wire logic serial_out_od_o,
   input wire logic serial_out_od_oe_n,
   input wire swl_pkg::swl_code_t wiper_ch1,
   input wire swl_pkg::swl_code_t wiper_ch2,
   input wire swl_pkg::swl_code_t wiper_ch3,
   input wire swl_pkg::swl_code_t wiper_ch4,
   input wire logic [swl_pkg::NUM_CH-1:0] term_a_open,
   input wire logic wiper_load
);
   // ****
   // helper logic
   // ****
   // terminals that the variant really has; absent channels never open
   localparam logic [3:0] PRESENT = (CHANNELS == swl_pkg::CH_QUAD) ? 4'hf :
      (CHANNELS == swl_pkg::CH_DUAL) ? 4'h3 : 4'h1;
   // link edges since reset, power-down or an edge with select high, held at 15; first two after reset are lost
   logic [3:0] run_q;
   logic [3:0] run_d;
   always_comb begin
      run_d = run_q;
      if (!power_down_n || chip_sel_n) begin
         run_d = 4'h0;
      end else if (run_q != 4'hf) begin
         run_d = run_q + 4'h1;
      end
   end
   always_ff @(posedge link_clk or posedge srst) begin
      if (srst) begin
         run_q <= 4'h0;
      end else begin
         run_q <= run_d;
      end
   end
   sequence pd_held_s;
      !power_down_n [*3];
   endsequence
   sequence mid_held_s;
      (!midscale_reset_n && power_down_n) [*4];
   endsequence

   // ****
   // assertions
   // ****
   load_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
      wiper_load |=> !wiper_load) else $error("load strobe longer than one cycle");
   load_cause_a: assert property (@(posedge core_clk) disable iff (srst)
      $rose(wiper_load) |-> $past(chip_sel_n, 2) && !$past(chip_sel_n, 4)) else $error("load without select rise");
   load_timely_a: assert property (@(posedge core_clk) disable iff (srst)
      (CHANNELS == 4) && $rose(chip_sel_n) |-> ##[1:4] wiper_load) else $error("select rise not decoded");
   load_one_a: assert property (@(posedge core_clk) disable iff (srst)
      wiper_load |-> $countones({wiper_ch1 != $past(wiper_ch1), wiper_ch2 != $past(wiper_ch2),
      wiper_ch3 != $past(wiper_ch3), wiper_ch4 != $past(wiper_ch4)}) <= 1) else $error("several wipers loaded");
   midscale_a: assert property (@(posedge core_clk) disable iff (srst)
      mid_held_s |=> wiper_ch1 == swl_pkg::MIDSCALE_CODE && wiper_ch4 == swl_pkg::MIDSCALE_CODE)
      else $error("midscale not forced");
   pd_wipers_a: assert property (@(posedge core_clk) disable iff (srst)
      pd_held_s |=> term_a_open == PRESENT && wiper_ch1 == swl_pkg::WIPER_AT_B) else $error("power-down not applied");
   pd_release_a: assert property (@(posedge core_clk) disable iff (srst)
      $rose(power_down_n) |-> ##3 term_a_open == 4'h0) else $error("power-down not left");
   sdo_pd_a: assert property (@(posedge core_clk) disable iff (srst)
      pd_held_s ##1 !power_down_n |-> serial_out_od_oe_n) else $error("serial output active in power-down");
   od_value_a: assert property (@(posedge core_clk) disable iff (srst)
      serial_out_od_o == swl_pkg::OD_LOW) else $error("open-drain output drives high");
   od_shift_a: assert property (@(posedge link_clk) disable iff (srst)
      run_q >= 4'hc |-> serial_out_od_oe_n == $past(serial_in, 10)) else $error("serial output not shifted through");
endmodule : swl_loader_chk
`default_nettype wire

bind swl_loader swl_loader_chk #(.CHANNELS(CHANNELS)) u_chk (.core_clk(core_clk), .srst(srst),
   .link_clk(link_clk), .chip_sel_n(chip_sel_n), .serial_in(serial_in), .midscale_reset_n(midscale_reset_n),
   .power_down_n(power_down_n), .serial_out_od_i(serial_out_od_i), .serial_out_od_o(serial_out_od_o),
   .serial_out_od_oe_n(serial_out_od_oe_n), .wiper_ch1(wiper_ch1), .wiper_ch2(wiper_ch2),
   .wiper_ch3(wiper_ch3), .wiper_ch4(wiper_ch4), .term_a_open(term_a_open), .wiper_load(wiper_load));

// ==== verification/swl_loader_bench.sv ====
// self-checking bench for the serial wiper latch loader
`timescale 1ns/1ps
`default_nettype none
module swl_loader_bench;
   // ****
   // signals and instances
   // ****
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic midscale_reset_n = 1'b1;
   logic power_down_n = 1'b1;
   logic link_clk, chip_sel_n, serial_in, od_o, od_oe_n, wiper_load;
   wire logic od_wire;
   swl_pkg::swl_code_t wiper_ch1, wiper_ch2, wiper_ch3, wiper_ch4;
   logic [3:0] term_a_open;
   wire logic [3:0][7:0] wv_dual, wv_one;
   wire logic [3:0] ta_dual, ta_one;
   swl_pkg::swl_code_t lat [3][4];
   int chans [3] = '{swl_pkg::CH_QUAD, swl_pkg::CH_DUAL, swl_pkg::CH_SINGLE};
   int errors = 0;
   int num_checks = 0;
   int seed = 2064;
   int cycles = 0;

   always #20 core_clk = ~core_clk;
   assign od_wire = od_oe_n ? 1'b1 : od_o; // pull-up wins when released
   swl_host_model host (.link_clk(link_clk), .chip_sel_n(chip_sel_n), .serial_in(serial_in));
   swl_loader #(.CHANNELS(swl_pkg::CH_QUAD)) DUT (.core_clk(core_clk), .srst(srst), .link_clk(link_clk),
      .chip_sel_n(chip_sel_n), .serial_in(serial_in), .midscale_reset_n(midscale_reset_n),
      .power_down_n(power_down_n), .serial_out_od_i(od_wire), .serial_out_od_o(od_o),
      .serial_out_od_oe_n(od_oe_n), .wiper_ch1(wiper_ch1), .wiper_ch2(wiper_ch2), .wiper_ch3(wiper_ch3),
      .wiper_ch4(wiper_ch4), .term_a_open(term_a_open), .wiper_load(wiper_load));
   // narrower variants share the link, so every frame exercises all three decodes
   swl_loader #(.CHANNELS(swl_pkg::CH_DUAL)) DUT_DUAL (.core_clk(core_clk), .srst(srst), .link_clk(link_clk),
      .chip_sel_n(chip_sel_n), .serial_in(serial_in), .midscale_reset_n(midscale_reset_n),
      .power_down_n(power_down_n), .serial_out_od_i(od_wire), .serial_out_od_o(), .serial_out_od_oe_n(),
      .wiper_ch1(wv_dual[0]), .wiper_ch2(wv_dual[1]), .wiper_ch3(wv_dual[2]), .wiper_ch4(wv_dual[3]),
      .term_a_open(ta_dual), .wiper_load());
   swl_loader #(.CHANNELS(swl_pkg::CH_SINGLE)) DUT_ONE (.core_clk(core_clk), .srst(srst), .link_clk(link_clk),
      .chip_sel_n(chip_sel_n), .serial_in(serial_in), .midscale_reset_n(midscale_reset_n),
      .power_down_n(power_down_n), .serial_out_od_i(od_wire), .serial_out_od_o(), .serial_out_od_oe_n(),
      .wiper_ch1(wv_one[0]), .wiper_ch2(wv_one[1]), .wiper_ch3(wv_one[2]), .wiper_ch4(wv_one[3]),
      .term_a_open(ta_one), .wiper_load());

   // ****
   // checking helpers
   // ****
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // power-down shows wiper at B, latches kept underneath
   // variant 0 quad, 1 dual, 2 single; absent channels keep midscale
   function automatic swl_pkg::swl_code_t exp_wiper(input int v, input int ch);
      return (!power_down_n && ch < chans[v]) ? swl_pkg::WIPER_AT_B : lat[v][ch];
   endfunction : exp_wiper

   task automatic check_all();
      check(wiper_ch1, exp_wiper(0, 0));
      check(wiper_ch2, exp_wiper(0, 1));
      check(wiper_ch3, exp_wiper(0, 2));
      check(wiper_ch4, exp_wiper(0, 3));
      for (int c = 0; c < 4; c++) begin
         check(wv_dual[c], exp_wiper(1, c));
         check(wv_one[c], exp_wiper(2, c));
      end
   endtask : check_all

   // midscale everywhere, as the reset pin leaves it
   task automatic mid_all();
      for (int v = 0; v < 3; v++) begin
         for (int c = 0; c < 4; c++) begin
            lat[v][c] = swl_pkg::MIDSCALE_CODE;
         end
      end
   endtask : mid_all

   // a masked write leaves midscale; six cycles exceed decode and spacing
   task automatic write(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      host.send({2'($random(seed)), a, d});
      if (midscale_reset_n) begin
         lat[0][a] = d;
         lat[2][0] = d;
         if (!a[1]) begin
            lat[1][a] = d;
         end
      end
      repeat (6) @(posedge core_clk);
      #1;
      check_all();
      // top of the register is the first address bit; released reads high
      check(8'(od_wire), 8'(power_down_n ? a[1] : 1'b1));
   endtask : write

   // hang guard, run needs about 610 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end

   // ****
   // scenarios
   // ****
   initial begin
      repeat (4) @(posedge core_clk);
      #1 srst = 1'b0;
      mid_all();
      repeat (4) @(posedge core_clk);
      #1;
      check_all();
      check(8'(term_a_open), 8'h00);
      for (int a = 0; a < 4; a++) begin
         write(a[1:0], 8'h00);
         write(a[1:0], 8'hff);
      end
      repeat (16) write(2'($random(seed)), 8'($random(seed)));
      @(posedge core_clk);
      #1 midscale_reset_n = 1'b0;
      mid_all();
      write(2'h2, 8'h5a);
      @(posedge core_clk);
      #1 midscale_reset_n = 1'b1;
      write(2'h1, 8'h33);
      @(posedge core_clk);
      #1 power_down_n = 1'b0;
      write(2'h3, 8'hc3);
      check(8'(term_a_open), 8'h0f);
      check(8'(ta_dual), 8'h03);
      check(8'(ta_one), 8'h01);
      check(8'(od_wire), 8'h01);
      @(posedge core_clk);
      #1 power_down_n = 1'b1;
      repeat (6) @(posedge core_clk);
      #1;
      check_all();
      check(8'(term_a_open), 8'h00);
      check(8'(ta_dual), 8'h00);
      summarize();
   end
endmodule : swl_loader_bench
`default_nettype wire
